// ==== hw/bmsa_top.sv ====
/*
 Bus master: operand sizing into bus cycles, cycle states, arbitration.
 Assumes a core issues one operand request at a time and slaves follow
 the strobe and acknowledge handshake.
*/
// Contract
// - Byte aligned; odd word, non-quad long misaligned
// - Any data address accepted, extra cycles
// - Odd instruction prefetch raises address error
// - Long at 001: long code, byte moved
// - Second cycle three bytes, address 010
// - Third cycle one byte, address 100
// - Reads split exactly like writes
// - Read data latched at end of S4
// - S5 negates strobes, holds address info
// - Wired-OR requests, several active tolerated
// - Grant negated few cycles after acknowledge
// - Pending request reasserts grant within few
// - Arbitration works in reset, halt, double fault; here halt only (HALTED_I), reset holds grant negated
// - Adapt cycle to 8/16/32-bit port ack
// - Inputs synchronised before use
`default_nettype none
module bmsa_top (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   // Operand request
   input wire logic REQ_VALID_I,
   input wire logic REQ_WRITE_I,
   input wire logic REQ_PREFETCH_I,
   input wire logic [1:0] REQ_SIZE_I,
   input wire logic [31:0] REQ_ADDR_I,
   input wire logic [31:0] REQ_WDATA_I,
   input wire logic [2:0] REQ_FC_I,
   input wire logic HALTED_I,
   output logic REQ_READY_O,
   output logic DONE_O,
   output logic ADDR_ERR_O,
   output logic MISALIGNED_O,
   output logic [31:0] RDATA_O,
   // External bus
   output logic [31:0] ADDR_O,
   output logic [1:0] SIZE_O,
   output logic RW_O,
   output logic [2:0] FC_O,
   output logic ADDRESS_STROBE_N_O,
   output logic DATA_STROBE_N_O,
   output logic DATA_BUFFER_ENABLE_N_O,
   output logic [31:0] DATA_O,
   output logic DATA_OE_O,
   input wire logic [31:0] DATA_I,
   input wire logic [1:0] PORT_SIZE_ACK_N_I,
   // Arbitration
   input wire logic BUS_REQUEST_N_I,
   input wire logic GRANT_ACKNOWLEDGE_N_I,
   output logic BUS_GRANT_N_O
);
   bmsa_sync_if syn ();
   bmsa_sync u_sync (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .ack_n_i(PORT_SIZE_ACK_N_I),
      .req_n_i(BUS_REQUEST_N_I),
      .gack_n_i(GRANT_ACKNOWLEDGE_N_I),
      .data_i(DATA_I),
      .out(syn.src)
   );

   // Bytes moved by port width from given address offset
   function automatic logic [2:0] port_bytes(input logic [1:0] ack,
      input logic [1:0] a, input logic [2:0] rem);
      logic [2:0] cap;
      cap = 3'h4;
      unique case (ack)
         bmsa_pkg::ACK_PORT8: cap = 3'h1;
         bmsa_pkg::ACK_PORT16: cap = 3'h2 - {2'h0, a[0]};
         default: cap = 3'h4 - {1'b0, a};
      endcase
      port_bytes = (cap < rem) ? cap : rem;
   endfunction

   function automatic logic [1:0] size_code(input logic [2:0] rem);
      size_code = rem[1:0];
   endfunction

   bmsa_pkg::bmsa_bus_t st, next_st;
   logic [31:0] addr, next_addr;
   logic [2:0] rem, next_rem;
   logic [31:0] wbuf, next_wbuf;
   logic [31:0] rbuf, next_rbuf;
   logic rw, next_rw;
   logic [2:0] fc, next_fc;
   logic as_n, next_as_n, ds_n, next_ds_n, den_n, next_den_n;
   logic ready, next_ready, done, next_done, aerr, next_aerr;
   logic mis, next_mis, doe, next_doe;
   logic [2:0] moved;

   always_comb begin
      next_st = st;
      next_addr = addr;
      next_rem = rem;
      next_wbuf = wbuf;
      next_rbuf = rbuf;
      next_rw = rw;
      next_fc = fc;
      next_as_n = as_n;
      next_ds_n = ds_n;
      next_den_n = den_n;
      next_ready = ready;
      next_done = 1'b0;
      next_aerr = 1'b0;
      next_mis = mis;
      next_doe = doe;
      moved = port_bytes(syn.ack_n, addr[1:0], rem);
      unique case (st)
         bmsa_pkg::BMSA_IDLE: begin
            if (REQ_VALID_I && ready) begin
               if (REQ_PREFETCH_I && REQ_ADDR_I[0]) begin
                  next_aerr = 1'b1;
                  next_done = 1'b1;
               end else if (BUS_GRANT_N_O && syn.gack_n) begin
                  next_st = bmsa_pkg::BMSA_S0;
                  next_ready = 1'b0;
                  next_addr = REQ_ADDR_I;
                  next_rem = (REQ_SIZE_I == bmsa_pkg::SIZE_LONG) ? 3'h4 :
                             {1'b0, REQ_SIZE_I};
                  next_wbuf = REQ_WDATA_I;
                  next_rbuf = 32'h0;
                  next_rw = ~REQ_WRITE_I;
                  next_fc = REQ_FC_I;
                  next_mis = (REQ_SIZE_I == bmsa_pkg::SIZE_WORD &&
                              REQ_ADDR_I[0]) ||
                             (REQ_SIZE_I == bmsa_pkg::SIZE_LONG &&
                              REQ_ADDR_I[1:0] != 2'h0);
               end
            end
         end
         bmsa_pkg::BMSA_S0: begin
            if (syn.ack_n == bmsa_pkg::ACK_NONE) begin
               next_as_n = 1'b0;
               next_ds_n = ~rw;
               next_den_n = 1'b0;
               next_doe = ~rw;
               next_st = bmsa_pkg::BMSA_S2;
            end
         end
         bmsa_pkg::BMSA_S2: begin
            next_ds_n = 1'b0;
            if (syn.ack_n != bmsa_pkg::ACK_NONE) begin
               next_st = bmsa_pkg::BMSA_S4;
            end
         end
         bmsa_pkg::BMSA_S4: begin
            if (rw) begin
               next_rbuf = (rbuf << {moved, 3'h0}) |
                  (syn.data >> {3'h4 - moved, 3'h0});
            end
            next_as_n = 1'b1;
            next_ds_n = 1'b1;
            next_den_n = 1'b1;
            next_wbuf = wbuf << {moved, 3'h0};
            next_st = bmsa_pkg::BMSA_S5;
         end
         bmsa_pkg::BMSA_S5: begin
            next_doe = 1'b0;
            next_rem = rem - moved;
            next_addr = addr + {29'h0, moved};
            if (rem == moved) begin
               next_st = bmsa_pkg::BMSA_IDLE;
               next_done = 1'b1;
               next_ready = 1'b1;
            end else begin
               next_st = bmsa_pkg::BMSA_S0;
            end
         end
         default: next_st = bmsa_pkg::BMSA_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         st <= bmsa_pkg::BMSA_IDLE;
         addr <= 32'h0;
         rem <= 3'h0;
         wbuf <= 32'h0;
         rbuf <= 32'h0;
         rw <= 1'b1;
         fc <= 3'h0;
         as_n <= 1'b1;
         ds_n <= 1'b1;
         den_n <= 1'b1;
         ready <= 1'b1;
         done <= 1'b0;
         aerr <= 1'b0;
         mis <= 1'b0;
         doe <= 1'b0;
      end else begin
         st <= next_st;
         addr <= next_addr;
         rem <= next_rem;
         wbuf <= next_wbuf;
         rbuf <= next_rbuf;
         rw <= next_rw;
         fc <= next_fc;
         as_n <= next_as_n;
         ds_n <= next_ds_n;
         den_n <= next_den_n;
         ready <= next_ready;
         done <= next_done;
         aerr <= next_aerr;
         mis <= next_mis;
         doe <= next_doe;
      end
   end

   // Arbitration
   bmsa_pkg::bmsa_arb_t arb, next_arb;
   logic [2:0] cnt, next_cnt;
   logic bg_n, next_bg_n;
   always_comb begin
      next_arb = arb;
      next_cnt = cnt;
      next_bg_n = bg_n;
      unique case (arb)
         bmsa_pkg::BMSA_ARB_IDLE: begin
            if (!syn.req_n && (st == bmsa_pkg::BMSA_IDLE || HALTED_I)) begin
               next_bg_n = 1'b0;
               next_arb = bmsa_pkg::BMSA_ARB_GRANT;
            end
         end
         bmsa_pkg::BMSA_ARB_GRANT: begin
            if (!syn.gack_n) begin
               next_cnt = bmsa_pkg::GRANT_NEG_CYCLES;
               next_arb = bmsa_pkg::BMSA_ARB_OWNED;
            end else if (syn.req_n) begin
               next_bg_n = 1'b1;
               next_arb = bmsa_pkg::BMSA_ARB_IDLE;
            end
         end
         bmsa_pkg::BMSA_ARB_OWNED: begin
            if (cnt != 3'h0) begin
               next_cnt = cnt - 3'h1;
            end else begin
               next_bg_n = 1'b1;
               next_cnt = bmsa_pkg::GRANT_REASSERT_CYCLES;
               next_arb = bmsa_pkg::BMSA_ARB_GAP;
            end
         end
         bmsa_pkg::BMSA_ARB_GAP: begin
            if (cnt != 3'h0) begin
               next_cnt = cnt - 3'h1;
            end else if (!syn.req_n) begin
               next_bg_n = 1'b0;
               next_arb = bmsa_pkg::BMSA_ARB_GRANT;
            end else if (syn.gack_n) begin
               next_arb = bmsa_pkg::BMSA_ARB_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         arb <= bmsa_pkg::BMSA_ARB_IDLE;
         cnt <= 3'h0;
         bg_n <= 1'b1;
      end else begin
         arb <= next_arb;
         cnt <= next_cnt;
         bg_n <= next_bg_n;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
         BUS_GRANT_N_O <= 1'b1;
         ADDR_O <= 32'h0;
         SIZE_O <= 2'h0;
         RW_O <= 1'b1;
         FC_O <= 3'h0;
         ADDRESS_STROBE_N_O <= 1'b1;
         DATA_STROBE_N_O <= 1'b1;
         DATA_BUFFER_ENABLE_N_O <= 1'b1;
         DATA_O <= 32'h0;
         DATA_OE_O <= 1'b0;
         REQ_READY_O <= 1'b0;
         DONE_O <= 1'b0;
         ADDR_ERR_O <= 1'b0;
         MISALIGNED_O <= 1'b0;
         RDATA_O <= 32'h0;
      end else begin
         BUS_GRANT_N_O <= next_bg_n;
         ADDR_O <= next_addr;
         SIZE_O <= size_code(next_rem);
         RW_O <= next_rw;
         FC_O <= next_fc;
         ADDRESS_STROBE_N_O <= next_as_n;
         DATA_STROBE_N_O <= next_ds_n;
         DATA_BUFFER_ENABLE_N_O <= next_den_n;
         DATA_O <= next_wbuf;
         DATA_OE_O <= next_doe;
         REQ_READY_O <= next_ready;
         DONE_O <= next_done;
         ADDR_ERR_O <= next_aerr;
         MISALIGNED_O <= next_mis;
         RDATA_O <= next_rbuf;
      end
   end

   property p_prefetch_err;
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (REQ_VALID_I && ready && REQ_PREFETCH_I && REQ_ADDR_I[0])
         |=> (ADDR_ERR_O && st == bmsa_pkg::BMSA_IDLE);
   endproperty
   a_prefetch_err: assert property (p_prefetch_err)
      else $error("odd prefetch did not fault");
   property p_s5_hold;
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (st == bmsa_pkg::BMSA_S5) |-> (ADDRESS_STROBE_N_O &&
         DATA_STROBE_N_O && DATA_BUFFER_ENABLE_N_O &&
         $stable(ADDR_O) && $stable(SIZE_O) && $stable(RW_O));
   endproperty
   a_s5_hold: assert property (p_s5_hold)
      else $error("S5 strobes or address wrong");
   property p_second_cycle;
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (st == bmsa_pkg::BMSA_S5 && addr[2:0] == 3'h1 && rem == 3'h4 &&
       syn.ack_n == bmsa_pkg::ACK_PORT16)
         |=> (ADDR_O[2:0] == 3'h2 && SIZE_O == bmsa_pkg::SIZE_THREE);
   endproperty
   a_second_cycle: assert property (p_second_cycle)
      else $error("second misaligned cycle wrong");
   property p_third_cycle;
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (st == bmsa_pkg::BMSA_S5 && addr[2:0] == 3'h2 && rem == 3'h3 &&
       syn.ack_n == bmsa_pkg::ACK_PORT16)
         |=> (ADDR_O[2:0] == 3'h4 && SIZE_O == bmsa_pkg::SIZE_BYTE);
   endproperty
   a_third_cycle: assert property (p_third_cycle)
      else $error("third misaligned cycle wrong");
   property p_first_cycle;
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (st == bmsa_pkg::BMSA_IDLE && REQ_VALID_I && ready &&
       !REQ_PREFETCH_I && BUS_GRANT_N_O && syn.gack_n &&
       REQ_SIZE_I == bmsa_pkg::SIZE_LONG && REQ_ADDR_I[2:0] == 3'h1)
         |=> (SIZE_O == bmsa_pkg::SIZE_LONG && ADDR_O[2:0] == 3'h1
              && MISALIGNED_O);
   endproperty
   a_first_cycle: assert property (p_first_cycle)
      else $error("first misaligned cycle wrong");
   property p_read_latch;
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (st == bmsa_pkg::BMSA_S4 && rw && rem == 3'h4 &&
       syn.ack_n == bmsa_pkg::ACK_PORT32 && addr[1:0] == 2'h0)
         |=> (rbuf == $past(syn.data));
   endproperty
   a_read_latch: assert property (p_read_latch)
      else $error("read data not latched at S4");
   property p_grant_drop;
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (arb == bmsa_pkg::BMSA_ARB_GRANT && !syn.gack_n)
         |-> ##[1:5] BUS_GRANT_N_O;
   endproperty
   a_grant_drop: assert property (p_grant_drop)
      else $error("grant not negated after acknowledge");
   property p_grant_again;
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (arb == bmsa_pkg::BMSA_ARB_GAP && cnt == 3'h0 && !syn.req_n)
         |=> !BUS_GRANT_N_O;
   endproperty
   a_grant_again: assert property (p_grant_again)
      else $error("grant not reasserted for pending request");
   c_split: cover property (@(posedge CLK_SYS_I)
      st == bmsa_pkg::BMSA_S5 && rem == 3'h1);
   c_grant: cover property (@(posedge CLK_SYS_I)
      arb == bmsa_pkg::BMSA_ARB_OWNED);
   c_fault: cover property (@(posedge CLK_SYS_I) ADDR_ERR_O);
endmodule
`default_nettype wire

// ==== hw/bmsa_pkg.sv ====
/*
 Package for the bus master sizing and arbitration block.
 Assumes a single 100 MHz processor clock.
*/
`default_nettype none
package bmsa_pkg;
   // Transfer size codes
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_THREE = 2'h3;
   // Port size acknowledge codes, active low: {ack1_n, ack0_n}
   localparam logic [1:0] ACK_PORT32 = 2'h0;
   localparam logic [1:0] ACK_PORT8 = 2'h2;
   localparam logic [1:0] ACK_PORT16 = 2'h1;
   localparam logic [1:0] ACK_NONE = 2'h3;
   // Arbitration delays in clock cycles
   localparam logic [2:0] GRANT_NEG_CYCLES = 3'h2;
   localparam logic [2:0] GRANT_REASSERT_CYCLES = 3'h2;
   // Bus states, Gray from IDLE through S5; S5 back to IDLE or S0 is not
   typedef enum logic [2:0] {
      BMSA_IDLE = 3'h0,
      BMSA_S0 = 3'h1,
      BMSA_S2 = 3'h3,
      BMSA_S4 = 3'h2,
      BMSA_S5 = 3'h6
   } bmsa_bus_t;
   typedef enum logic [1:0] {
      BMSA_ARB_IDLE = 2'h0,
      BMSA_ARB_GRANT = 2'h1,
      BMSA_ARB_OWNED = 2'h3,
      BMSA_ARB_GAP = 2'h2
   } bmsa_arb_t;
endpackage
`default_nettype wire

// ==== hw/bmsa_sync_if.sv ====
/*
 Interface carrying synchronised bus inputs to the core.
 Assumes the synchroniser drives and the core only reads.
*/
`default_nettype none
interface bmsa_sync_if;
   logic [1:0] ack_n;
   logic req_n;
   logic gack_n;
   logic [31:0] data;
   modport src (output ack_n, output req_n, output gack_n, output data);
   modport dst (input ack_n, input req_n, input gack_n, input data);
endinterface
`default_nettype wire

// ==== hw/bmsa_sync.sv ====
/*
 Two flop synchroniser for the asynchronous bus inputs.
 Assumes inputs may change at any time relative to the clock.
*/
`default_nettype none
module bmsa_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] ack_n_i,
   input wire logic req_n_i,
   input wire logic gack_n_i,
   input wire logic [31:0] data_i,
   bmsa_sync_if.src out
);
   logic [35:0] meta;
   logic [35:0] stab;
   logic [35:0] next_meta;
   logic [35:0] next_stab;
   always_comb begin
      next_meta = {ack_n_i, req_n_i, gack_n_i, data_i};
      next_stab = meta;
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta <= {4'hf, 32'h0};
         stab <= {4'hf, 32'h0};
      end else begin
         meta <= next_meta;
         stab <= next_stab;
      end
   end
   assign out.ack_n = stab[35:34];
   assign out.req_n = stab[33];
   assign out.gack_n = stab[32];
   assign out.data = stab[31:0];
endmodule
`default_nettype wire

// ==== bench/bmsa_slave.sv ====
/*
 Partner model: a slave memory with selectable port width and wait.
 Assumes the bench sets port code and wait between operands.
*/
`default_nettype none
module bmsa_slave (
   // Clock and log clear
   input wire logic clk_i,
   input wire logic clr_i,
   // Bus from the master
   input wire logic [31:0] addr_i,
   input wire logic [1:0] size_i,
   input wire logic rw_i,
   input wire logic as_n_i,
   input wire logic ds_n_i,
   input wire logic [31:0] wdata_i,
   // Setup
   input wire logic [1:0] port_i,
   input wire logic [3:0] wait_i,
   // Answer
   output logic [31:0] rdata_o,
   output logic [1:0] ack_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:15];
   logic [2:0] lo [0:7];
   logic [1:0] sz [0:7];
   int ncyc = 0;
   int cnt = 0;
   logic busy = 1'b0;

   initial begin
      rdata_o = 32'h0;
      ack_n_o = bmsa_pkg::ACK_NONE;
   end

   // Bytes moved in this cycle
   function automatic int nbytes();
      int pb;
      int rem;
      pb = (port_i == bmsa_pkg::ACK_PORT8) ? 1 :
         (port_i == bmsa_pkg::ACK_PORT16) ? 2 : 4;
      rem = (size_i == 2'h0) ? 4 : int'(size_i);
      pb = pb - int'(addr_i[1:0]) % pb;
      return (rem < pb) ? rem : pb;
   endfunction

   always @(posedge clk_i) begin
      if (clr_i) begin
         ncyc <= 0;
      end
      if (!busy && !as_n_i && !ds_n_i) begin
         if (cnt < int'(wait_i)) begin
            cnt <= cnt + 1;
         end else begin
            ack_n_o <= port_i;
            busy <= 1'b1;
            lo[ncyc[2:0]] <= addr_i[2:0];
            sz[ncyc[2:0]] <= size_i;
            ncyc <= ncyc + 1;
            for (int i = 0; i < 4; i++) begin
               if (i < nbytes() && !rw_i) begin
                  mem[addr_i[3:0] + 4'(i)] <= wdata_i[31 - 8 * i -: 8];
               end
               rdata_o[31 - 8 * i -: 8] <= (i < nbytes()) ?
                  mem[addr_i[3:0] + 4'(i)] : ~rdata_o[31 - 8 * i -: 8];
            end
         end
      end else if (busy && (as_n_i || ds_n_i)) begin
         ack_n_o <= bmsa_pkg::ACK_NONE;
         rdata_o <= ~rdata_o;
         busy <= 1'b0;
         cnt <= 0;
      end
   end
endmodule
`default_nettype wire

// ==== bench/test_bmsa_top.sv ====
/*
 Self-checking bench for the bus master sizing and arbitration block.
 Assumes the slave model answers strobed cycles and the bench plays
 the alternate bus masters.
*/
`default_nettype none
module test_bmsa_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic vld = 1'b0;
   logic wr = 1'b0;
   logic pf = 1'b0;
   logic halt = 1'b0;
   logic [1:0] sz = 2'h0;
   logic [2:0] fci = 3'h1;
   logic [31:0] ad = 32'h0;
   logic [31:0] wd = 32'h0;
   logic req_a_n = 1'b1;
   logic req_b_n = 1'b1;
   logic gack_n = 1'b1;
   logic breq_n;
   logic [1:0] port = bmsa_pkg::ACK_PORT32;
   logic [3:0] wt = 4'h0;
   logic rdy, done, aerr, mis, rw, as_n, ds_n, data_buffer_enable_n_n, bg_n, e, doe;
   logic [31:0] rdata, addr, dout, din;
   logic [1:0] size, ack_n;
   logic [2:0] fc;
   logic [37:0] held;
   logic was_as = 1'b1;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;

   always #5 clk = ~clk;
   assign breq_n = req_a_n & req_b_n;

   bmsa_top u_bmsa_top (
      .CLK_SYS_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(vld),
      .REQ_WRITE_I(wr), .REQ_PREFETCH_I(pf), .REQ_SIZE_I(sz),
      .REQ_ADDR_I(ad), .REQ_WDATA_I(wd), .REQ_FC_I(fci),
      .HALTED_I(halt), .REQ_READY_O(rdy), .DONE_O(done),
      .ADDR_ERR_O(aerr), .MISALIGNED_O(mis), .RDATA_O(rdata),
      .ADDR_O(addr), .SIZE_O(size), .RW_O(rw), .FC_O(fc),
      .ADDRESS_STROBE_N_O(as_n), .DATA_STROBE_N_O(ds_n),
      .DATA_BUFFER_ENABLE_N_O(data_buffer_enable_n_n), .DATA_O(dout), .DATA_OE_O(doe),
      .DATA_I(din), .PORT_SIZE_ACK_N_I(ack_n),
      .BUS_REQUEST_N_I(breq_n), .GRANT_ACKNOWLEDGE_N_I(gack_n),
      .BUS_GRANT_N_O(bg_n)
   );
   bmsa_slave u_bmsa_slave (
      .clk_i(clk), .clr_i(vld), .addr_i(addr), .size_i(size), .rw_i(rw),
      .as_n_i(as_n), .ds_n_i(ds_n), .wdata_i(dout), .port_i(port),
      .wait_i(wt), .rdata_o(din), .ack_n_o(ack_n)
   );

   task automatic chk(input string w, input logic [31:0] x, g);
      total_checks++;
      if (g !== x) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", w, x, g);
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         end_of_test();
      end
   end

   // Cycle end: strobes off, address side held
   always @(negedge clk) begin
      if (!as_n) begin
         held <= {addr, size, rw, fc};
         chk("data enable", 32'(!rw), 32'(doe));
         chk("read write", 32'(!wr), 32'(rw));
         chk("function code", 32'(fci), 32'(fc));
      end
      if (!was_as && as_n) begin
         chk("s5 address", held[37:6], addr);
         chk("s5 control", 32'(held[5:0]), 32'({size, rw, fc}));
         chk("s5 strobes", 32'h7, 32'({as_n, ds_n, data_buffer_enable_n_n}));
      end
      was_as <= as_n;
   end

   function automatic logic [1:0] sc(input logic [3:0] r);
      case (r)
         4'h1: return bmsa_pkg::SIZE_BYTE;
         4'h2: return bmsa_pkg::SIZE_WORD;
         4'h3: return bmsa_pkg::SIZE_THREE;
         default: return bmsa_pkg::SIZE_LONG;
      endcase
   endfunction

   function automatic logic [1:0] pc(input int b);
      return (b == 1) ? bmsa_pkg::ACK_PORT8 :
         (b == 2) ? bmsa_pkg::ACK_PORT16 : bmsa_pkg::ACK_PORT32;
   endfunction

   function automatic logic [31:0] mw(input int a);
      return {u_bmsa_slave.mem[a], u_bmsa_slave.mem[a + 1],
         u_bmsa_slave.mem[a + 2], u_bmsa_slave.mem[a + 3]};
   endfunction

   task automatic op(input logic w, p, input logic [1:0] s,
      input logic [31:0] a, d);
      int n;
      @(negedge clk);
      vld <= 1'b1;
      wr <= w;
      pf <= p;
      sz <= s;
      ad <= a;
      wd <= d;
      fci <= p ? 3'h6 : 3'h1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rdy && !aerr && n < 50);
      vld <= 1'b0;
      e = aerr;
      while (!done && n < 300) begin
         @(negedge clk);
         n++;
      end
   endtask

   // Digits of el are low address bits, of es remaining bytes
   task automatic log(input int n, input logic [15:0] el, es);
      chk("bus cycles", 32'(n), 32'(u_bmsa_slave.ncyc));
      for (int i = 0; i < n; i++) begin
         chk("low address", 32'(el[15 - 4 * i -: 4]),
            32'(u_bmsa_slave.lo[i]));
         chk("size code", 32'(sc(es[15 - 4 * i -: 4])),
            32'(u_bmsa_slave.sz[i]));
      end
   endtask

   task automatic cs(input int pb, ob, input logic [31:0] a,
      input logic m, input int n, input logic [15:0] el, es);
      port <= pc(pb);
      op(1'b1, 1'b0, sc(4'(ob)), a, 32'h5a6b7c8d);
      chk("misaligned", 32'(m), 32'(mis));
      log(n, el, es);
   endtask

   task automatic gwait(input logic v, output int n);
      n = 0;
      while (bg_n !== v && n < 12) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic s_mis();
      port <= pc(2);
      op(1'b1, 1'b0, sc(4'h4), 32'h1, 32'ha1b2c3d4);
      log(3, 16'h1240, 16'h4310);
      chk("misaligned", 32'h1, 32'(mis));
      chk("memory", 32'ha1b2c3d4, mw(1));
      wt <= 4'h3;
      op(1'b0, 1'b0, sc(4'h4), 32'h1, 32'h0);
      log(3, 16'h1240, 16'h4310);
      chk("read data", 32'ha1b2c3d4, rdata);
      wt <= 4'h0;
   endtask

   task automatic s_align();
      cs(4, 1, 32'h3, 1'b0, 1, 16'h3000, 16'h1000);
      cs(4, 2, 32'h2, 1'b0, 1, 16'h2000, 16'h2000);
      cs(4, 2, 32'h3, 1'b1, 2, 16'h3400, 16'h2100);
      cs(4, 4, 32'h4, 1'b0, 1, 16'h4000, 16'h4000);
      cs(4, 4, 32'h2, 1'b1, 2, 16'h2400, 16'h4200);
      cs(1, 4, 32'h0, 1'b0, 4, 16'h0123, 16'h4321);
      cs(2, 4, 32'h0, 1'b0, 2, 16'h0200, 16'h4200);
      port <= pc(4);
      op(1'b0, 1'b0, sc(4'h4), 32'h0, 32'h0);
      log(1, 16'h0000, 16'h4000);
      chk("aligned read", 32'h5a6b7c8d, rdata);
      cs(2, 3, 32'h1, 1'b0, 2, 16'h1200, 16'h3200);
   endtask

   task automatic s_pref();
      port <= pc(4);
      op(1'b0, 1'b1, sc(4'h2), 32'h3, 32'h0);
      chk("address error", 32'h1, 32'(e));
      log(0, 16'h0, 16'h0);
      op(1'b0, 1'b1, sc(4'h2), 32'h2, 32'h0);
      chk("address error", 32'h0, 32'(e));
      log(1, 16'h2000, 16'h2000);
   endtask

   task automatic s_arb_one();
      int n;
      @(negedge clk);
      req_a_n <= 1'b0;
      gwait(1'b0, n);
      chk("grant given", 32'h1, 32'(n < 12));
      @(negedge clk);
      gack_n <= 1'b0;
      req_a_n <= 1'b1;
      gwait(1'b1, n);
      chk("grant dropped", 32'h1, 32'(n < 12));
      @(negedge clk);
      vld <= 1'b1;
      repeat (8) begin
         @(negedge clk);
         chk("strobe while owned", 32'h1, 32'(as_n));
      end
      vld <= 1'b0;
      gack_n <= 1'b1;
      repeat (6) @(negedge clk);
      chk("grant idle", 32'h1, 32'(bg_n));
   endtask

   task automatic s_arb_multi();
      int n;
      @(negedge clk);
      req_a_n <= 1'b0;
      req_b_n <= 1'b0;
      gwait(1'b0, n);
      chk("grant two", 32'h1, 32'(n < 12));
      @(negedge clk);
      gack_n <= 1'b0;
      req_a_n <= 1'b1;
      gwait(1'b1, n);
      chk("grant dropped", 32'h1, 32'(n < 12));
      gwait(1'b0, n);
      chk("grant again", 32'h1, 32'(n < 12));
      @(negedge clk);
      req_b_n <= 1'b1;
      gwait(1'b1, n);
      chk("grant last", 32'h1, 32'(n < 12));
      @(negedge clk);
      gack_n <= 1'b1;
      repeat (6) @(negedge clk);
   endtask

   task automatic s_halt();
      int n;
      wt <= 4'ha;
      fork
         op(1'b1, 1'b0, sc(4'h4), 32'h8, 32'h11223344);
         begin
            n = 0;
            while (as_n && n < 50) begin
               @(negedge clk);
               n++;
            end
            halt <= 1'b1;
            req_a_n <= 1'b0;
            gwait(1'b0, n);
            chk("grant in cycle", 32'h0, 32'(bg_n | as_n));
         end
      join
      chk("halted write", 32'h11223344, mw(8));
      @(negedge clk);
      gack_n <= 1'b0;
      req_a_n <= 1'b1;
      halt <= 1'b0;
      wt <= 4'h0;
      gwait(1'b1, n);
      @(negedge clk);
      gack_n <= 1'b1;
      repeat (6) @(negedge clk);
   endtask

   initial begin
      repeat (16) @(negedge clk);
      chk("reset outputs", 32'h1e, 32'({as_n, ds_n, data_buffer_enable_n_n, bg_n, rdy}));
      rst_n <= 1'b1;
      repeat (3) @(negedge clk);
      s_mis();
      s_align();
      s_pref();
      s_arb_one();
      s_arb_multi();
      s_halt();
      end_of_test();
   end
endmodule
`default_nettype wire
